// [hdl/quad_dac_map.vh]
// Constants for the quad DAC serial input port
`ifndef QUAD_DAC_MAP_VH
`define QUAD_DAC_MAP_VH
`define SHIFT_LEN 32
`define WORD_LEN 24
`define CMD_MSB 23
`define CMD_LSB 20
`define CHAN_MSB 19
`define CHAN_LSB 16
`define DATA_MSB 15
`define DATA_LSB 0
`define CMD_WRITE 4'h0
`define CMD_UPDATE 4'h1
`define CMD_WRITE_UPDATE_ALL 4'h2
`define CMD_WRITE_UPDATE 4'h3
`define CMD_POWER_DOWN 4'h4
`define CMD_NOP 4'hF
`define CHAN_ALL 4'hF
`define CODE_RESET 16'h0000
`define SHIFT_RESET 32'h00000000
`endif

// [hdl/quad_dac_serial_input_port.v]
// Serial input port and register bank of a quad DAC
`timescale 1ns/1ps
`include "quad_dac_map.vh"

module quad_dac_serial_input_port (
    input wire clk_sys,
    input wire reset_n,
    input wire async_clear_n,
    input wire shift_clock,
    input wire serial_in,
    input wire select_load_n,
    output reg chain_serial_out,
    output reg [15:0] code_a,
    output reg [15:0] code_b,
    output reg [15:0] code_c,
    output reg [15:0] code_d,
    output reg [3:0] powered_down
);

    // ========================================
    // Reset and clear
    // Either low level clears every flop at once, independent of any clock
    wire rst_n;
    assign rst_n = reset_n & async_clear_n;

    // Release is synchronised: a clear lifting close to an edge could
    // otherwise let the shift register run while the decode is still held
    reg [1:0] clear_sync;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clear_sync <= 2'h0;
        end else begin
            clear_sync <= {clear_sync[0], 1'b1};
        end
    end

    // Loads and shifts stay blocked for two cycles after release
    wire run_ok;
    assign run_ok = clear_sync[1];

    // ========================================
    // Pin synchronisers
    reg [1:0] sck_sync;
    reg [1:0] data_sync;
    reg [1:0] csl_sync;

    // Shift clock pin, two flops deep before any edge logic
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sck_sync <= 2'h0;
        end else begin
            sck_sync <= {sck_sync[0], shift_clock};
        end
    end

    // Data pin, same depth as the clock so setup at the pin is kept
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            data_sync <= 2'h0;
        end else begin
            data_sync <= {data_sync[0], serial_in};
        end
    end

    // Select pin, reset high so the idle line reads as deselected
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            csl_sync <= 2'h3;
        end else begin
            csl_sync <= {csl_sync[0], select_load_n};
        end
    end

    // ========================================
    // Edge detection
    // Last levels reset to the idle pin levels, so reset makes no false edge
    reg sck_last;
    reg csl_last;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sck_last <= 1'b0;
            csl_last <= 1'b1;
        end else begin
            sck_last <= sck_sync[1];
            csl_last <= csl_sync[1];
        end
    end

    // Pin edges are seen three system cycles late; each link clock phase
    // must therefore last at least three system cycles
    wire sck_rise;
    wire sck_fall;
    wire load_rise;
    wire shift_enable;
    assign sck_rise = sck_sync[1] & ~sck_last;
    assign sck_fall = ~sck_sync[1] & sck_last;
    assign shift_enable = sck_rise & ~csl_sync[1] & run_ok;
    assign load_rise = csl_sync[1] & ~csl_last & run_ok;

    // ========================================
    // Shift register and chain output
    reg [31:0] shift_reg;
    // Shifts only while selected; a high select leaves the clock ignored
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= `SHIFT_RESET;
        end else if (shift_enable) begin
            shift_reg <= {shift_reg[30:0], data_sync[1]};
        end
    end

    // Bit 31 has seen 32 rising edges; it is shown on the falling edge,
    // so a downstream part sampling on the rise sees a settled bit
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            chain_serial_out <= 1'b0;
        end else if (sck_fall) begin
            chain_serial_out <= shift_reg[`SHIFT_LEN-1];
        end
    end

    // ========================================
    // Command decode from the low 24 bits, so the pad byte never matters
    wire [3:0] cmd;
    wire [3:0] chan;
    wire [15:0] data;
    assign cmd = shift_reg[`CMD_MSB:`CMD_LSB];
    assign chan = shift_reg[`CHAN_MSB:`CHAN_LSB];
    assign data = shift_reg[`DATA_MSB:`DATA_LSB];

    // One-hot channel selection, all four on CHAN_ALL; reserved codes select nothing
    reg [3:0] sel;
    always @* begin
        case (chan)
            4'h0: sel = 4'h1;
            4'h1: sel = 4'h2;
            4'h2: sel = 4'h4;
            4'h3: sel = 4'h8;
            `CHAN_ALL: sel = 4'hF;
            default: sel = 4'h0;
        endcase
    end

    // ========================================
    // Input registers, DAC registers and power state
    reg [15:0] in_reg [0:3];
    reg [15:0] next_in [0:3];
    reg [3:0] do_write;
    reg [3:0] do_update;
    reg [3:0] do_down;
    integer i;
    integer j;

    // Command table; unknown commands behave as no operation
    always @* begin
        do_write = 4'h0;
        do_update = 4'h0;
        do_down = 4'h0;
        case (cmd)
            `CMD_WRITE: do_write = sel;
            `CMD_UPDATE: do_update = sel;
            `CMD_WRITE_UPDATE_ALL: begin
                do_write = sel;
                do_update = 4'hF;
            end
            `CMD_WRITE_UPDATE: begin
                do_write = sel;
                do_update = sel;
            end
            `CMD_POWER_DOWN: do_down = sel;
            `CMD_NOP: do_write = 4'h0;
            default: do_write = 4'h0;
        endcase
        for (i = 0; i < 4; i = i + 1) begin
            next_in[i] = do_write[i] ? data : in_reg[i];
        end
    end

    // Input registers take the word only on the load edge
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (j = 0; j < 4; j = j + 1) begin
                in_reg[j] <= `CODE_RESET;
            end
        end else if (load_rise) begin
            for (j = 0; j < 4; j = j + 1) begin
                in_reg[j] <= next_in[j];
            end
        end
    end

    // Active codes; an update copies the freshly written input value,
    // so write-and-update needs no second frame
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            code_a <= `CODE_RESET;
            code_b <= `CODE_RESET;
            code_c <= `CODE_RESET;
            code_d <= `CODE_RESET;
        end else if (load_rise) begin
            if (do_update[0]) begin
                code_a <= next_in[0];
            end
            if (do_update[1]) begin
                code_b <= next_in[1];
            end
            if (do_update[2]) begin
                code_c <= next_in[2];
            end
            if (do_update[3]) begin
                code_d <= next_in[3];
            end
        end
    end

    // Power-down leaves both register sets alone; any update wakes the
    // channel again in the same load
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            powered_down <= 4'h0;
        end else if (load_rise) begin
            powered_down <= (powered_down | do_down) & ~do_update;
        end
    end

endmodule

// [verification/quad_dac_serial_input_port_properties.sv]
// Timing checks on the quad DAC serial input port
`timescale 1ns/1ps
module quad_dac_props (
    input wire clk_sys,
    input wire reset_n,
    input wire async_clear_n,
    input wire shift_clock,
    input wire serial_in,
    input wire select_load_n,
    input wire chain_serial_out,
    input wire [15:0] code_a,
    input wire [15:0] code_b,
    input wire [15:0] code_c,
    input wire [15:0] code_d,
    input wire [3:0] powered_down
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Codes and power state may only move a few cycles after a load edge, the chain output after a clock fall
    clear_codes_a: assert property (
        !async_clear_n |-> !{code_a, code_b, code_c, code_d, powered_down}) else $error("clr");
    clear_chain_a: assert property (
        !async_clear_n |-> !chain_serial_out) else $error("clr out");
    load_timing_a: assert property (
        $changed(code_a) && async_clear_n |-> $past(select_load_n, 3) && !$past(select_load_n, 6))
        else $error("code_a");
    power_timing_a: assert property (
        $changed(powered_down) && async_clear_n |-> $past(select_load_n, 3)) else $error("pd");
    other_timing_a: assert property (
        $changed({code_b, code_c, code_d}) && async_clear_n |-> $past(select_load_n, 3))
        else $error("codes");
    hold_low_a: assert property (
        !select_load_n [*6] |-> $stable({code_a, code_d, powered_down})) else $error("hold");
    chain_fall_a: assert property (
        $changed(chain_serial_out) && async_clear_n |-> $past(shift_clock, 6) && !$past(shift_clock, 2))
        else $error("chain");
    chain_idle_a: assert property (
        select_load_n [*8] ##0 async_clear_n |-> $stable(chain_serial_out)) else $error("idle");
endmodule
bind quad_dac_serial_input_port quad_dac_props u_props (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_clear_n(async_clear_n),
    .shift_clock(shift_clock),
    .serial_in(serial_in),
    .select_load_n(select_load_n),
    .chain_serial_out(chain_serial_out),
    .code_a(code_a),
    .code_b(code_b),
    .code_c(code_c),
    .code_d(code_d),
    .powered_down(powered_down)
);

// [verification/serial_master_model.sv]
// Serial master driving frames into the port
`timescale 1ns/1ps
module serial_master (
    input wire clk_sys,
    output reg shift_clock,
    output reg serial_in,
    output reg select_load_n
);
    initial {shift_clock, serial_in, select_load_n} = 3'b001;
    // Link clock stands low outside frames except during idle_clocks pulses; 80 ns period inside
    task send(input [31:0] word, input integer bits);
        integer i;
        begin
            select_load_n = 0;
            for (i = bits - 1; i >= 0; i = i - 1) begin
                serial_in = word[i];
                repeat (4) @(negedge clk_sys);
                shift_clock = 1;
                repeat (4) @(negedge clk_sys);
                shift_clock = 0;
            end
            repeat (4) @(negedge clk_sys);
            select_load_n = 1;
            serial_in = ~serial_in; // No stale bit after release
            repeat (8) @(negedge clk_sys);
        end
    endtask
    // Clock pulses while deselected, zeros on data; the port must ignore them
    task idle_clocks(input integer pulses);
        integer k;
        begin
            serial_in = 1'b0;
            for (k = 0; k < pulses; k = k + 1) begin
                repeat (4) @(negedge clk_sys);
                shift_clock = 1;
                repeat (4) @(negedge clk_sys);
                shift_clock = 0;
            end
            repeat (8) @(negedge clk_sys);
        end
    endtask
endmodule

// [verification/quad_dac_serial_input_port_bench.sv]
// Testbench for the quad DAC serial input port
`timescale 1ns/1ps
`include "quad_dac_map.vh"
module quad_dac_serial_input_port_bench;
    reg clk_sys = 0;
    reg reset_n = 0;
    reg async_clear_n = 1;
    integer mismatches = 0;
    integer checks_done = 0;
    integer i;
    wire shift_clock, serial_in, select_load_n, chain_serial_out;
    wire [15:0] code_a, code_b, code_c, code_d;
    wire [3:0] powered_down;
    always #5 clk_sys = ~clk_sys;
    serial_master u_master (
        .clk_sys(clk_sys),
        .shift_clock(shift_clock),
        .serial_in(serial_in),
        .select_load_n(select_load_n)
    );
    quad_dac_serial_input_port u_dut (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .async_clear_n(async_clear_n),
        .shift_clock(shift_clock),
        .serial_in(serial_in),
        .select_load_n(select_load_n),
        .chain_serial_out(chain_serial_out),
        .code_a(code_a),
        .code_b(code_b),
        .code_c(code_c),
        .code_d(code_d),
        .powered_down(powered_down)
    );
    task chk(input [15:0] got, input [15:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", checks_done, mismatches);
            if (mismatches == 0 && checks_done > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task sc_channels;
        begin
            for (i = 0; i < 4; i = i + 1)
                u_master.send({`CMD_WRITE_UPDATE, i[3:0], 16'hA5C0 + i[15:0]}, 24);
            chk(code_a, 16'hA5C0);
            chk(code_c, 16'hA5C2);
            chk(code_d, 16'hA5C3);
        end
    endtask
    task sc_long_word;
        begin
            u_master.send({8'hA5, `CMD_WRITE, 4'h0, 16'h1234}, 32);
            chk(code_a, 16'hA5C0);
            u_master.send({`CMD_UPDATE, 4'h0, 16'h0}, 24);
            chk(code_a, 16'h1234);
        end
    endtask
    task sc_power;
        begin
            u_master.send({`CMD_POWER_DOWN, `CHAN_ALL, 16'hFFFF}, 24);
            chk(powered_down, 16'hF);
            chk(code_b, 16'hA5C1);
            u_master.send({`CMD_WRITE_UPDATE_ALL, 4'h1, 16'h0BB0}, 24);
            chk(powered_down, 16'h0);
            chk(code_b, 16'h0BB0);
        end
    endtask
    task sc_chain;
        begin
            u_master.send(32'h7FFFFF80, 32);
            chk(chain_serial_out, 16'h0);
            u_master.send(32'hFF0000, 24);
            chk(chain_serial_out, 16'h1);
            chk(code_a, 16'h1234);
            u_master.idle_clocks(8);
            chk(chain_serial_out, 16'h1);
        end
    endtask
    task sc_clear;
        begin
            async_clear_n = 0;
            repeat (2) @(negedge clk_sys);
            chk(code_b, 16'h0);
            chk(chain_serial_out, 16'h0);
            chk(code_a, 16'h0);
            async_clear_n = 1;
            repeat (3) @(negedge clk_sys);
            u_master.send({`CMD_WRITE_UPDATE, 4'h2, 16'h5AA5}, 24);
            chk(code_c, 16'h5AA5);
        end
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches = mismatches + 1;
        complete_run;
    end
    initial begin
        repeat (2) @(negedge clk_sys);
        reset_n = 1;
        repeat (3) @(negedge clk_sys);
        sc_channels;
        sc_long_word;
        sc_power;
        sc_chain;
        sc_clear;
        complete_run;
    end
endmodule
